// ### uam_serial_ctrl.sv
/*
  Two asynchronous serial channels with their mode, error status and
  baud clock registers, reached by byte or single-bit CPU accesses.
  Assumes all inputs synchronous to clk_sys_i; transmit bytes arrive on
  a valid/ready port and received bytes leave through a two-entry buffer.
*/
// Functional notes
// - Reset clears mode, status, baud registers
// - Registers are 8-bit, bit or byte access
// - Enable bits pick stop, receive, transmit, both
// - Parity field: none, zero, odd, even
// - Length bit: seven or eight data bits
// - Stop length bit: one or two stops
// - Receiver checks only one stop bit
// - Suppress bit withholds completion on error
// - Infrared bit selects infrared framing
// - Status: parity 2, framing 1, overrun 0
// - Odd or even parity mismatch sets parity error
// - Missing stop bit sets framing error
// - Overrun repeats until buffer read
// - Source select picks pin, divided clock, timer
// - Divide source by sixteen plus k
// - Seven-bit mode drops bit seven
`timescale 1ns/1ns
`include "uam_cfg.svh"
module uam_serial_ctrl (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // CPU register access.
  input wire logic [19:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_bit_i,
  input wire logic [2:0] cpu_bit_sel_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  // Clock sources.
  input wire logic [1:0] ext_serial_clock_pin_i,
  input wire logic timer1_output_i,
  // Serial pins.
  input wire logic serial_in_pin_ch1_i,
  input wire logic serial_in_pin_ch2_i,
  output logic serial_out_pin_ch1_o,
  output logic serial_out_pin_ch2_o,
  output logic [1:0] rx_serial_fn_o,
  output logic [1:0] tx_serial_fn_o,
  // Transmit data, one byte lane per channel.
  input wire logic [1:0][7:0] tx_data_i,
  input wire logic [1:0] tx_valid_i,
  output logic [1:0] tx_ready_o,
  // Receive data; taking a byte is the buffer read.
  output logic [1:0][7:0] rx_data_o,
  output logic [1:0] rx_valid_o,
  input wire logic [1:0] rx_ready_i,
  // Event pulses.
  output logic [1:0] rx_done_irq_o,
  output logic [1:0] rx_err_irq_o,
  output logic [1:0] tx_done_irq_o
);
  import uam_pkg::*;

  logic [7:0] mode_q [2];
  logic [7:0] baud_q [2];
  logic [2:0] stat_w [2];
  logic [7:0] rdata_q;
  logic [4:0] pre_q;
  logic tmr_q;
  logic [1:0] rxd;
  logic [1:0] txd;

  // ********
  // CPU register access
  // ********

  // A bit access rewrites only the selected bit with wdata bit 0.
  function automatic logic [7:0] wr_merge(input logic [7:0] old);
    logic [7:0] m;
    m = 8'h01 << cpu_bit_sel_i;
    wr_merge = cpu_bit_i ? ((old & ~m) | (cpu_wdata_i[0] ? m : 8'h00)) : cpu_wdata_i;
  endfunction

  // Mode and baud writes; status is read-only and ignores writes.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_q[0] <= `UAM_REG_RST;
      mode_q[1] <= `UAM_REG_RST;
      baud_q[0] <= `UAM_REG_RST;
      baud_q[1] <= `UAM_REG_RST;
    end else if (cpu_wr_i) begin
      if (cpu_addr_i == `UAM_MODE_CH1_ADDR) begin
        mode_q[0] <= wr_merge(mode_q[0]);
      end else if (cpu_addr_i == `UAM_MODE_CH2_ADDR) begin
        mode_q[1] <= wr_merge(mode_q[1]);
      end else if (cpu_addr_i == `UAM_BAUD_CH1_ADDR) begin
        baud_q[0] <= wr_merge(baud_q[0]);
      end else if (cpu_addr_i == `UAM_BAUD_CH2_ADDR) begin
        baud_q[1] <= wr_merge(baud_q[1]);
      end
    end
  end

  // Read data is registered; a bit read returns the whole byte.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd_i) begin
      if (cpu_addr_i == `UAM_MODE_CH1_ADDR) begin
        rdata_q <= mode_q[0];
      end else if (cpu_addr_i == `UAM_MODE_CH2_ADDR) begin
        rdata_q <= mode_q[1];
      end else if (cpu_addr_i == `UAM_STAT_CH1_ADDR) begin
        rdata_q <= {5'h00, stat_w[0]};
      end else if (cpu_addr_i == `UAM_STAT_CH2_ADDR) begin
        rdata_q <= {5'h00, stat_w[1]};
      end else if (cpu_addr_i == `UAM_BAUD_CH1_ADDR) begin
        rdata_q <= baud_q[0];
      end else if (cpu_addr_i == `UAM_BAUD_CH2_ADDR) begin
        rdata_q <= baud_q[1];
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign cpu_rdata_o = rdata_q;

  // ********
  // Prescaler and pins
  // ********

  // Free-running divider of the system clock, tapped per channel.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pre_q <= 5'h00;
      tmr_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 5'h01;
      tmr_q <= timer1_output_i;
    end
  end

  assign rxd = {serial_in_pin_ch2_i, serial_in_pin_ch1_i};
  assign serial_out_pin_ch1_o = txd[0];
  assign serial_out_pin_ch2_o = txd[1];

  // ********
  // Channels
  // ********
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [7:0] mode;
    logic [7:0] baud;
    uam_parity_t par;
    logic txe, rxe, cl, sl, isrm, ir;
    logic src_en, ext_q, tick;
    logic [4:0] div_q;
    uam_state_t tx_st_q, rx_st_q;
    logic [3:0] tx_ph_q, rx_ph_q;
    logic [2:0] tx_idx_q, rx_idx_q;
    logic [7:0] tx_sh_q, rx_sh_q, rx_word_q;
    logic tx_par_q, tx_stop2_q, tx_lvl, txd_q, tx_done_q;
    logic rx_bit_q, rx_perr_q, rx_ferr_q, rx_push_q, rx_err;
    logic [2:0] stat_q;
    logic [7:0] tx_word, rx_word;
    uam_buf_if u_if();

    assign mode = mode_q[c];
    assign baud = baud_q[c];
    assign txe = mode[`UAM_TXE_BIT];
    assign rxe = mode[`UAM_RXE_BIT];
    assign par = uam_parity_t'(mode[`UAM_PAR_HI:`UAM_PAR_LO]);
    assign cl = mode[`UAM_CL_BIT];
    assign sl = mode[`UAM_SL_BIT];
    assign isrm = mode[`UAM_ISRM_BIT];
    assign ir = mode[`UAM_IR_BIT];
    // Pins serve the channel only for the enabled direction.
    assign rx_serial_fn_o[c] = rxe;
    assign tx_serial_fn_o[c] = txe;

    // Source clock enable; external and timer sources count rising edges.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        ext_q <= 1'b0;
      end else begin
        ext_q <= ext_serial_clock_pin_i[c];
      end
    end
    always_comb begin
      case (baud[`UAM_SRC_HI:`UAM_SRC_LO])
        3'h0: src_en = ext_serial_clock_pin_i[c] & ~ext_q;
        3'h1: src_en = 1'b1;
        3'h2: src_en = pre_q[0];
        3'h3: src_en = &pre_q[1:0];
        3'h4: src_en = &pre_q[2:0];
        3'h5: src_en = &pre_q[3:0];
        3'h6: src_en = &pre_q[4:0];
        default: src_en = timer1_output_i & ~tmr_q;
      endcase
    end

    // Divide by sixteen plus k; k of fifteen would be unused by software.
    // Infrared pulse stays three of sixteen ticks per bit for any k.
    assign tick = src_en && (div_q == (`UAM_DIV_BASE + {1'b0, baud[`UAM_DIV_HI:`UAM_DIV_LO]}));
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !(txe || rxe)) begin
        div_q <= 5'h00;
      end else if (tick) begin
        div_q <= 5'h00;
      end else if (src_en) begin
        div_q <= div_q + 5'h01;
      end
    end

    // Transmit byte with bit 7 dropped in seven-bit mode.
    assign tx_word = cl ? tx_data_i[c] : {1'b0, tx_data_i[c][6:0]};
    assign tx_ready_o[c] = txe && (tx_st_q == UAM_IDLE);

    // Transmit sequencer; disabling the direction aborts the frame.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !txe) begin
        tx_st_q <= UAM_IDLE;
        tx_idx_q <= 3'h0;
        tx_sh_q <= 8'hff;
        tx_par_q <= 1'b0;
        tx_stop2_q <= 1'b0;
        tx_done_q <= 1'b0;
      end else begin
        tx_done_q <= 1'b0;
        case (tx_st_q)
          UAM_IDLE: begin
            if (tx_valid_i[c]) begin
              tx_sh_q <= tx_word;
              tx_par_q <= (par == UAM_PAR_ODD) ? ~^tx_word :
                          (par == UAM_PAR_EVEN) ? ^tx_word : 1'b0;
              tx_st_q <= UAM_START;
            end
          end
          UAM_START: begin
            if (tick && tx_ph_q == `UAM_PH_LAST) begin
              tx_st_q <= UAM_DATA;
              tx_idx_q <= 3'h0;
            end
          end
          UAM_DATA: begin
            if (tick && tx_ph_q == `UAM_PH_LAST) begin
              tx_sh_q <= {1'b1, tx_sh_q[7:1]};
              tx_idx_q <= tx_idx_q + 3'h1;
              if (tx_idx_q == (cl ? 3'h7 : 3'h6)) begin
                tx_st_q <= (par == UAM_PAR_NONE) ? UAM_STOP : UAM_PAR;
                tx_stop2_q <= sl;
              end
            end
          end
          UAM_PAR: begin
            if (tick && tx_ph_q == `UAM_PH_LAST) begin
              tx_st_q <= UAM_STOP;
            end
          end
          UAM_STOP: begin
            if (tick && tx_ph_q == `UAM_PH_LAST) begin
              if (tx_stop2_q) begin
                tx_stop2_q <= 1'b0;
              end else begin
                tx_st_q <= UAM_IDLE;
                tx_done_q <= 1'b1;
              end
            end
          end
          default: tx_st_q <= UAM_IDLE;
        endcase
      end
    end

    // Bit phase counter, sixteen ticks per bit.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || tx_st_q == UAM_IDLE) begin
        tx_ph_q <= 4'h0;
      end else if (tick) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
    end

    // Line level of the current bit: low start, high stop and idle.
    always_comb begin
      case (tx_st_q)
        UAM_START: tx_lvl = 1'b0;
        UAM_DATA: tx_lvl = tx_sh_q[0];
        UAM_PAR: tx_lvl = tx_par_q;
        default: tx_lvl = 1'b1;
      endcase
    end

    // Infrared sends a short high pulse for each zero bit, else idles low.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        txd_q <= 1'b1;
      end else begin
        txd_q <= ir ? (~tx_lvl && tx_ph_q < `UAM_IR_PULSE) : tx_lvl;
      end
    end
    assign txd[c] = txd_q;
    assign tx_done_irq_o[c] = tx_done_q;

    // Bit detector: mid-bit sample, or any infrared pulse means zero.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        rx_bit_q <= 1'b1;
      end else if (tick) begin
        if (ir) begin
          rx_bit_q <= (rx_ph_q == 4'h0 ? 1'b1 : rx_bit_q) & ~rxd[c];
        end else if (rx_ph_q == `UAM_PH_SAMPLE) begin
          rx_bit_q <= rxd[c];
        end
      end
    end

    // Received byte with bit 7 forced to zero in seven-bit mode.
    assign rx_word = cl ? rx_sh_q : {1'b0, rx_sh_q[7:1]};

    // Receive sequencer.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !rxe) begin
        rx_st_q <= UAM_IDLE;
        rx_idx_q <= 3'h0;
        rx_sh_q <= 8'h00;
        rx_perr_q <= 1'b0;
        rx_ferr_q <= 1'b0;
        rx_push_q <= 1'b0;
        rx_word_q <= 8'hff;
      end else begin
        rx_push_q <= 1'b0;
        case (rx_st_q)
          UAM_IDLE: begin
            if (rxd[c] == ir) begin
              rx_st_q <= UAM_START;
              rx_perr_q <= 1'b0;
            end
          end
          UAM_START: begin
            if (tick && rx_ph_q == `UAM_PH_LAST) begin
              rx_st_q <= (rx_bit_q && !ir) ? UAM_IDLE : UAM_DATA;
              rx_idx_q <= 3'h0;
            end
          end
          UAM_DATA: begin
            if (tick && rx_ph_q == `UAM_PH_LAST) begin
              rx_sh_q <= {rx_bit_q, rx_sh_q[7:1]};
              rx_idx_q <= rx_idx_q + 3'h1;
              if (rx_idx_q == (cl ? 3'h7 : 3'h6)) begin
                rx_st_q <= (par == UAM_PAR_NONE) ? UAM_STOP : UAM_PAR;
              end
            end
          end
          UAM_PAR: begin
            if (tick && rx_ph_q == `UAM_PH_LAST) begin
              rx_st_q <= UAM_STOP;
              rx_perr_q <= (par == UAM_PAR_ODD && (^rx_word ^ rx_bit_q) != 1'b1) ||
                           (par == UAM_PAR_EVEN && (^rx_word ^ rx_bit_q) != 1'b0);
            end
          end
          UAM_STOP: begin
            // Only the first stop bit is checked, whatever the stop length.
            if (tick && rx_ph_q == `UAM_PH_LAST) begin
              rx_st_q <= UAM_IDLE;
              rx_ferr_q <= ~rx_bit_q;
              rx_word_q <= rx_word;
              rx_push_q <= 1'b1;
            end
          end
          default: rx_st_q <= UAM_IDLE;
        endcase
      end
    end

    // Receive bit phase counter.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || rx_st_q == UAM_IDLE) begin
        rx_ph_q <= 4'h0;
      end else if (tick) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
    end

    // Error status of the latest reception; a full buffer is an overrun.
    // The byte is dropped on overrun, and it recurs until software drains.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        stat_q <= 3'h0;
      end else if (rx_push_q) begin
        stat_q[`UAM_PE_BIT] <= rx_perr_q;
        stat_q[`UAM_FE_BIT] <= rx_ferr_q;
        stat_q[`UAM_OVE_BIT] <= ~u_if.in_ready;
      end
    end
    assign stat_w[c] = stat_q;

    // Completion events; the suppress bit hides completion on errors.
    assign rx_err = rx_perr_q || rx_ferr_q || !u_if.in_ready;
    assign rx_done_irq_o[c] = rx_push_q && !(rx_err && isrm);
    assign rx_err_irq_o[c] = rx_push_q && rx_err;

    // Receive buffer hookup.
    assign u_if.in_data = rx_word_q;
    assign u_if.in_valid = rx_push_q;
    assign u_if.out_ready = rx_ready_i[c];
    assign rx_data_o[c] = u_if.out_data;
    assign rx_valid_o[c] = u_if.out_valid;

    uam_rx_buf u_buf (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .bus(u_if.store)
    );
  end
endmodule

// ### uam_cfg.svh
/*
  Constants of the serial channel block.
  Assumes inclusion by bare name.
*/
`ifndef UAM_CFG_SVH
`define UAM_CFG_SVH

// ********
// Register addresses.
// ********
`define UAM_MODE_CH1_ADDR 20'h0_ff70
`define UAM_MODE_CH2_ADDR 20'h0_ff71
`define UAM_STAT_CH1_ADDR 20'h0_ff72
`define UAM_STAT_CH2_ADDR 20'h0_ff73
`define UAM_BAUD_CH1_ADDR 20'h0_ff76
`define UAM_BAUD_CH2_ADDR 20'h0_ff77

// ********
// Reset values.
// ********
`define UAM_REG_RST 8'h00

// ********
// Mode fields.
// ********
`define UAM_TXE_BIT 7
`define UAM_RXE_BIT 6
`define UAM_PAR_HI 5
`define UAM_PAR_LO 4
`define UAM_CL_BIT 3
`define UAM_SL_BIT 2
`define UAM_ISRM_BIT 1
`define UAM_IR_BIT 0

// ********
// Status and baud fields.
// ********
`define UAM_PE_BIT 2
`define UAM_FE_BIT 1
`define UAM_OVE_BIT 0
`define UAM_SRC_HI 6
`define UAM_SRC_LO 4
`define UAM_DIV_HI 3
`define UAM_DIV_LO 0

// ********
// Bit timing.
// ********
`define UAM_PH_LAST 4'hf
`define UAM_PH_SAMPLE 4'h7
`define UAM_IR_PULSE 4'h3
`define UAM_DIV_BASE 5'h0f

`endif

// ### uam_pkg.sv
/*
  Types shared by the serial channel control block.
  Assumes uam_cfg.svh is on the include path.
*/
package uam_pkg;

  // Frame sequencer states, one-hot.
  typedef enum logic [4:0] {
    UAM_IDLE  = 5'b0_0001,
    UAM_START = 5'b0_0010,
    UAM_DATA  = 5'b0_0100,
    UAM_PAR   = 5'b0_1000,
    UAM_STOP  = 5'b1_0000
  } uam_state_t;

  // Parity field encodings.
  typedef enum logic [1:0] {
    UAM_PAR_NONE = 2'h0,
    UAM_PAR_ZERO = 2'h1,
    UAM_PAR_ODD  = 2'h2,
    UAM_PAR_EVEN = 2'h3
  } uam_parity_t;

endpackage

// ### uam_buf_if.sv
/*
  Carrier between the receiver and its two-entry buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface uam_buf_if;
  logic [7:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [7:0] out_data;
  logic out_valid;
  logic out_ready;

  modport store (input in_data, input in_valid, input out_ready,
                 output in_ready, output out_data, output out_valid);
  modport user (output in_data, output in_valid, output out_ready,
                input in_ready, input out_data, input out_valid);
endinterface

// ### uam_rx_buf.sv
/*
  Two-entry buffer for received bytes, valid and ready on both sides.
  Assumes a synchronous active-high reset on the system clock.
*/
`timescale 1ns/1ns
module uam_rx_buf (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Fill and drain sides.
  uam_buf_if.store bus
);
  logic [7:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  // Full means the receiver has nowhere to put the next byte.
  assign bus.in_ready = (cnt_q != 2'h2);
  assign bus.out_valid = (cnt_q != 2'h0);
  assign bus.out_data = mem_q[rd_ptr_q];
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;

  // Storage and pointers.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      mem_q[0] <= 8'hff;
      mem_q[1] <= 8'hff;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= bus.in_data;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  // Fill level.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_q <= 2'h0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

// ### uam_ctrl_chk_sva.sv
/*
  Port checker of the serial block, channel one.
  Assumes a bind to uam_serial_ctrl.
*/
`timescale 1ns/1ns
`include "uam_cfg.svh"
module uam_ctrl_chk (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // CPU access.
  input wire logic [19:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_bit_i,
  input wire logic [2:0] cpu_bit_sel_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic [7:0] cpu_rdata_o,
  // Serial and stream side.
  input wire logic serial_out_pin_ch1_o,
  input wire logic [1:0] tx_serial_fn_o,
  input wire logic [1:0] tx_valid_i,
  input wire logic [1:0] tx_ready_o,
  input wire logic [1:0] rx_valid_o,
  input wire logic [1:0] rx_done_irq_o,
  input wire logic [1:0] tx_done_irq_o
);
  // ********
  // Properties.
  // ********
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // A taken byte drops ready and pulls the line to its start level.
  sequence s_take; tx_valid_i[0] && tx_ready_o[0]; endsequence
  sequence s_start_low; (!tx_ready_o[0] && !serial_out_pin_ch1_o) [*8]; endsequence
  // The reset check must run while reset is high, so it has its own disable.
  property p_rst_clear;
    disable iff (1'b0) sys_rst_i |=> cpu_rdata_o == 8'h00 && tx_serial_fn_o == 2'b00
      && rx_valid_o == 2'b00;
  endproperty
  property p_stat_read;
    cpu_rd_i && cpu_addr_i == `UAM_STAT_CH1_ADDR |=> cpu_rdata_o[7:3] == 5'h00;
  endproperty
  property p_unmapped;
    cpu_rd_i && cpu_addr_i == 20'h0_ff74 |=> cpu_rdata_o == 8'h00;
  endproperty
  property p_mode_byte;
    cpu_wr_i && !cpu_bit_i && cpu_addr_i == `UAM_MODE_CH1_ADDR
      |=> tx_serial_fn_o[0] == $past(cpu_wdata_i[7]);
  endproperty
  property p_mode_bit;
    cpu_wr_i && cpu_bit_i && cpu_bit_sel_i == 3'h7 && cpu_addr_i == `UAM_MODE_CH1_ADDR
      |=> tx_serial_fn_o[0] == $past(cpu_wdata_i[0]);
  endproperty
  property p_ready_off; !tx_serial_fn_o[0] |-> !tx_ready_o[0]; endproperty
  property p_take; s_take |=> ##1 s_start_low; endproperty
  property p_tx_done;
    tx_done_irq_o[0] |-> serial_out_pin_ch1_o ##1 (!tx_done_irq_o[0] && tx_ready_o[0]);
  endproperty
  property p_rx_done; rx_done_irq_o[0] |=> rx_valid_o[0]; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("registers not cleared by reset");
  a_stat_read: assert property (p_stat_read) else $error("status upper bits not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_mode_byte: assert property (p_mode_byte) else $error("transmit function wrong");
  a_mode_bit: assert property (p_mode_bit) else $error("bit write not applied");
  a_ready_off: assert property (p_ready_off) else $error("ready while disabled");
  a_take: assert property (p_take) else $error("start bit missing after take");
  a_tx_done: assert property (p_tx_done) else $error("done pulse not at stop end");
  a_rx_done: assert property (p_rx_done) else $error("completion without byte");
endmodule

// ### uam_line_model.sv
/*
  Remote asynchronous transceiver facing channel one.
  Assumes the bench sets bit_t, in 100 ns clock periods, before each frame.
*/
`timescale 1ns/1ns
module uam_line_model (
  // Line to the block's receiver.
  output logic line_o,
  // Line from the block's transmitter.
  input wire logic line_i
);
  // ********
  // Sender and sampler.
  // ********
  int bit_t = 256;
  logic [11:0] got;
  event got_ev;
  initial line_o = 1'b1;
  // Start bit, then n bits of v first bit first; the line idles high.
  task automatic send(input logic [11:0] v, input int n);
    line_o = 1'b0;
    #(bit_t * 100);
    for (int i = 0; i < n; i++) begin
      line_o = v[i];
      #(bit_t * 100);
    end
    line_o = 1'b1;
  endtask
  // Mid-bit samples; eleven bits span the longest frame.
  initial forever begin
    @(negedge line_i);
    #(bit_t * 50);
    for (int i = 0; i < 11; i++) begin
      #(bit_t * 100);
      got[i] = line_i;
    end
    got[11] = 1'b1;
    ->got_ev;
  end
endmodule

// ### uam_serial_ctrl_tb_top.sv
/*
  Self-checking bench of the serial block.
  Assumes a line model on channel one, loopback on two.
*/
`timescale 1ns/1ns
`include "uam_cfg.svh"
module uam_serial_ctrl_tb_top;
  import uam_pkg::*;
  // ********
  // Setup.
  // ********
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [19:0] cpu_addr_i = 20'h0_0000;
  logic cpu_wr_i = 1'b0;
  logic cpu_rd_i = 1'b0;
  logic cpu_bit_i = 1'b0;
  logic [2:0] cpu_bit_sel_i = 3'h0;
  logic [7:0] cpu_wdata_i = 8'h00;
  logic [7:0] cpu_rdata_o;
  logic [2:0] src_cnt_q = 3'h0;
  logic ser_in1, ser_out1, ser_out2, rd_q = 1'b0, stall = 1'b0;
  logic [1:0] rx_fn, tx_fn, tx_rdy, rx_vld, rx_done, rx_err, tx_done;
  logic [1:0] tx_valid_i = 2'b00, rx_ready_i = 2'b00;
  logic [1:0][7:0] tx_data_i = '0, rx_data;
  int err_count = 0, total_checks = 0;
  integer seed = 32'h9026f5ed;
  logic [7:0] q_rd[$], q_rx[2][$];
  logic [1:0] q_ev[$];
  logic [11:0] q_tx[$];
  logic [19:0] regs[6] = '{`UAM_MODE_CH1_ADDR, `UAM_MODE_CH2_ADDR, `UAM_STAT_CH1_ADDR,
    `UAM_STAT_CH2_ADDR, `UAM_BAUD_CH1_ADDR, `UAM_BAUD_CH2_ADDR};
  logic [7:0] bauds[5] = '{8'h10, 8'h00, 8'h20, 8'h70, 8'h1e};
  logic [7:0] modes[5] = '{8'h88, 8'h98, 8'ha0, 8'hb8, 8'hcc};
  int bits[5] = '{256, 512, 512, 1024, 480};
  uam_serial_ctrl u_dut (.clk_sys_i, .sys_rst_i, .cpu_addr_i, .cpu_wr_i, .cpu_rd_i,
    .cpu_bit_i, .cpu_bit_sel_i, .cpu_wdata_i, .cpu_rdata_o,
    .ext_serial_clock_pin_i({2{src_cnt_q[0]}}), .timer1_output_i(src_cnt_q[1]),
    .serial_in_pin_ch1_i(ser_in1), .serial_in_pin_ch2_i(ser_out2),
    .serial_out_pin_ch1_o(ser_out1), .serial_out_pin_ch2_o(ser_out2),
    .rx_serial_fn_o(rx_fn), .tx_serial_fn_o(tx_fn), .tx_data_i, .tx_valid_i,
    .tx_ready_o(tx_rdy), .rx_data_o(rx_data), .rx_valid_o(rx_vld), .rx_ready_i,
    .rx_done_irq_o(rx_done), .rx_err_irq_o(rx_err), .tx_done_irq_o(tx_done));
  uam_line_model u_mdl (.line_o(ser_in1), .line_i(ser_out1));
  // Clock, source clocks and a randomly stalling receiver.
  always #50 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) begin
    src_cnt_q <= src_cnt_q + 3'h1;
    rx_ready_i <= stall ? 2'b00 : 2'($random(seed));
  end
  // ********
  // Tasks.
  // ********
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b = 1'b0);
    @(negedge clk_sys_i);
    cpu_addr_i = a;
    cpu_wdata_i = d;
    cpu_bit_i = b;
    cpu_bit_sel_i = 3'h7;
    cpu_wr_i = 1'b1;
    @(negedge clk_sys_i);
    cpu_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    cpu_addr_i = a;
    cpu_bit_i = 1'b0;
    cpu_rd_i = 1'b1;
    q_rd.push_back(e);
    @(negedge clk_sys_i);
    cpu_rd_i = 1'b0;
  endtask
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  // Frame bits after the start bit.
  function automatic logic [11:0] frame(input logic [7:0] d, input logic cl,
                                        input uam_parity_t ps);
    logic [11:0] v;
    logic [7:0] dd;
    v = 12'hfff;
    dd = cl ? d : {1'b0, d[6:0]};
    for (int i = 0; i < 8; i++) if (i < 7 || cl) v[i] = d[i];
    if (ps != UAM_PAR_NONE) v[7 + cl] = ps == UAM_PAR_ODD ? ~^dd : ps == UAM_PAR_EVEN & ^dd;
    return v;
  endfunction
  // Waits for the watchers to use up every transmit and receive-data note, within a bound.
  task automatic wait_q();
    for (int i = 0; i < 40000 && (q_tx.size() + q_rx[0].size() + q_rx[1].size()) > 0; i++)
      @(negedge clk_sys_i);
    if (q_tx.size() + q_rx[0].size() + q_rx[1].size()) err_count++;
  endtask
  task automatic txf(input int ch, input logic [7:0] m, input logic [7:0] d);
    @(negedge clk_sys_i);
    tx_data_i[ch] = d;
    tx_valid_i[ch] = 1'b1;
    if (ch == 0) q_tx.push_back(frame(d, m[3], uam_parity_t'(m[5:4])));
    else q_rx[1].push_back(d);
    for (int i = 0; i < 100 && !tx_rdy[ch]; i++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    tx_valid_i[ch] = 1'b0;
    for (int i = 0; i < 40000 && !tx_done[ch]; i++) @(negedge clk_sys_i);
    if (!tx_done[ch]) err_count++;
    wait_q();
  endtask
  // Frame into channel one; flip damages bits, keep marks a stored byte.
  task automatic rxf(input logic [7:0] m, input logic [11:0] flip, input logic [7:0] st,
                     input logic [1:0] ev, input logic keep);
    logic [7:0] d;
    d = rnd();
    wr(`UAM_MODE_CH1_ADDR, m);
    if (keep) q_rx[0].push_back(m[3] ? d : {1'b0, d[6:0]});
    q_ev.push_back(ev);
    u_mdl.send(frame(d, m[3], uam_parity_t'(m[5:4])) ^ flip, 8 + m[3] + (m[5:4] != 2'b00));
    repeat (40) @(negedge clk_sys_i);
    rd(`UAM_STAT_CH1_ADDR, st);
  endtask
  // ********
  // Watchers and sequence.
  // ********
  always @(posedge clk_sys_i) begin
    if (rd_q) chk(cpu_rdata_o, q_rd.pop_front());
    rd_q <= cpu_rd_i;
    for (int c = 0; c < 2; c++)
      if (rx_vld[c] && rx_ready_i[c]) chk(rx_data[c], q_rx[c].pop_front());
    if (rx_done[0] || rx_err[0]) chk({rx_done[0], rx_err[0]}, q_ev.pop_front());
  end
  always @(u_mdl.got_ev) chk(u_mdl.got, q_tx.pop_front());
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_count++;
    end_of_test();
  end
  initial begin
    logic [7:0] r;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    r = rnd();
    wr(`UAM_MODE_CH2_ADDR, r);
    rd(`UAM_MODE_CH2_ADDR, r);
    chk({tx_fn, rx_fn}, {r[7], 1'b0, r[6], 1'b0});
    wr(`UAM_STAT_CH1_ADDR, 8'hff);
    rd(`UAM_STAT_CH1_ADDR, 8'h00);
    rd(20'h0_ff74, 8'h00);
    wr(`UAM_MODE_CH1_ADDR, 8'h01, 1'b1);
    rd(`UAM_MODE_CH1_ADDR, 8'h80);
    // Pin, undivided, halved and timer sources and a long divider; registers change only between frames.
    foreach (bauds[i]) begin
      wr(`UAM_BAUD_CH1_ADDR, bauds[i]);
      wr(`UAM_MODE_CH1_ADDR, modes[i]);
      u_mdl.bit_t = bits[i];
      txf(0, modes[i], rnd());
    end
    wr(`UAM_BAUD_CH1_ADDR, 8'h10);
    u_mdl.bit_t = 256;
    rxf(8'hf8, 12'h000, 8'h00, 2'b10, 1'b1);
    rxf(8'hc0, 12'h000, 8'h00, 2'b10, 1'b1);
    rxf(8'he8, 12'h100, 8'h04, 2'b11, 1'b1);
    rxf(8'hea, 12'h100, 8'h04, 2'b01, 1'b1);
    rxf(8'hd8, 12'h100, 8'h00, 2'b10, 1'b1);
    rxf(8'hc8, 12'h100, 8'h02, 2'b11, 1'b1);
    rxf(8'hcc, 12'h000, 8'h00, 2'b10, 1'b1);
    rxf(8'hcc, 12'h000, 8'h00, 2'b10, 1'b1);
    // Fill the buffer while stalled; later completions overrun until a byte is taken.
    wait_q();
    stall = 1'b1;
    for (int i = 0; i < 4; i++) rxf(8'hc8, 12'h000, {7'h00, i > 1}, {1'b1, i > 1}, i < 2);
    stall = 1'b0;
    wait_q();
    rxf(8'hc8, 12'h000, 8'h00, 2'b10, 1'b1);
    wr(`UAM_BAUD_CH2_ADDR, 8'h10);
    wr(`UAM_MODE_CH2_ADDR, 8'hf8);
    txf(1, 8'hf8, rnd());
    // Infrared transmit idles low; the divider stays at sixteen.
    wr(`UAM_MODE_CH1_ADDR, 8'h00);
    wr(`UAM_MODE_CH1_ADDR, 8'h81);
    repeat (4) @(negedge clk_sys_i);
    chk(ser_out1, 12'h000);
    end_of_test();
  end
endmodule
bind uam_serial_ctrl uam_ctrl_chk u_chk (.clk_sys_i, .sys_rst_i, .cpu_addr_i, .cpu_wr_i,
  .cpu_rd_i, .cpu_bit_i, .cpu_bit_sel_i, .cpu_wdata_i, .cpu_rdata_o, .serial_out_pin_ch1_o,
  .tx_serial_fn_o, .tx_valid_i, .tx_ready_o, .rx_valid_o, .rx_done_irq_o, .tx_done_irq_o);
